// file: inc/nvm_access_pkg.sv
/*
 Constants for the non-volatile configuration access block: register
 offsets, commands, field position, reset values and timing counts.
 Assumes a 100 MHz core clock.
*/
`default_nettype none
package nvm_access_pkg;
   // --------------------------------------------------------------
   // Timing
   // --------------------------------------------------------------
   localparam int CLK_MHZ = 100; // Core clock rate in MHz
   localparam int WINDOW_US = 10000; // Entry window after power-up, us
   localparam int WINDOW_CYC = WINDOW_US * CLK_MHZ; // Window, cycles
   localparam int PROC_US = 120; // Command and load processing, us
   localparam int PROC_CYC = PROC_US * CLK_MHZ; // Processing, cycles
   localparam int NVWRITE_US = 14000; // Non-volatile write time, us
   localparam int NVWRITE_CYC = NVWRITE_US * CLK_MHZ; // Write, cycles
   localparam int CNT_W = 21; // Width of the timing counters
   // --------------------------------------------------------------
   // Commands and register offsets
   // --------------------------------------------------------------
   localparam logic [7:0] CMD_ENTER = 8'ha0; // Enter programming mode
   localparam logic [7:0] CMD_EXIT = 8'h80; // Leave programming mode
   localparam logic [7:0] HUM_RES_RD = 8'h06; // humidity_resolution_read
   localparam logic [7:0] TMP_RES_RD = 8'h11; // temperature_resolution_read
   localparam logic [7:0] ID_UPPER_RD = 8'h1e; // sensor_id_upper
   localparam logic [7:0] ID_LOWER_RD = 8'h1f; // sensor_id_lower
   localparam logic [7:0] HUM_RES_WR = 8'h46; // humidity_resolution_write
   localparam logic [7:0] TMP_RES_WR = 8'h51; // temperature_resolution_write
   localparam logic [7:0] STATUS_OK = 8'h81; // Status byte on success
   localparam logic [7:0] STATUS_BUSY = 8'h00; // Status byte when not ready
   // --------------------------------------------------------------
   // Fields and reset values
   // --------------------------------------------------------------
   localparam int RES_MSB = 11; // Resolution field, upper bit
   localparam int RES_LSB = 10; // Resolution field, lower bit
   localparam logic [15:0] RES_REG_RESET = 16'h0c00; // 14-bit setting
endpackage : nvm_access_pkg
`default_nettype wire

// file: rtl/nvm_access.sv
/*
 Slave-side access to the sensor's non-volatile configuration: bus
 framing, programming-mode entry and exit, resolution registers and
 the identification number. Assumes SCL and SDA arrive asynchronously
 from a bus master and that the pad resolves SDA from SDA_OE.
*/
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - Settings and ID survive; only power-on resets
// - Registers reachable 120 us after entry
// - Every configuration register is 16 bits
// - Read offsets 06 humidity, 11 temperature
// - Write offsets 46 humidity, 51 temperature
// - Resolution field in bits 11:10, independent
// - Field 00/01/10/11 means 8/10/12/14 bits
// - Both resolutions default to 14 bits
// - Read returns status 81, high, low
// - ID upper at 1E, lower at 1F
// - Answer only own 7-bit address
module nvm_access #(
   parameter logic [6:0] SLAVE_ADDR = 7'h44, // Own bus address
   parameter logic [31:0] SENSOR_ID = 32'h5a5a_0001, // Arbitrary value
   parameter int WINDOW_CYC = nvm_access_pkg::WINDOW_CYC, // Entry window
   parameter int PROC_CYC = nvm_access_pkg::PROC_CYC, // Processing time
   parameter int NVWRITE_CYC = nvm_access_pkg::NVWRITE_CYC // Write time
) (
   input wire logic CORE_CLK, // Core clock, 100 MHz
   input wire logic RESETN, // Power-on reset, active low
   input wire logic SCL, // Bus clock from the master
   input wire logic SDA_IN, // Bus data level
   output logic SDA_OUT, // Bus data driven value, always low
   output logic SDA_OE, // High while pulling SDA low
   output logic PROG_MODE, // Programming mode active
   output logic [3:0] HUM_RES_BITS, // Humidity resolution in bits
   output logic [3:0] TEMP_RES_BITS // Temperature resolution in bits
);
   localparam int CW = nvm_access_pkg::CNT_W; // Counter width
   typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_RX_ACK, ST_TX, ST_TX_ACK} link_state_t;

   // Resolution field to conversion width
   function automatic logic [3:0] res_bits(input logic [1:0] f);
      case (f)
         2'h0: res_bits = 4'h8;
         2'h1: res_bits = 4'ha;
         2'h2: res_bits = 4'hc;
         default: res_bits = 4'he;
      endcase
   endfunction : res_bits

   // ----------------------------------------------------------------
   // Pin synchronisers and bus event detection
   // ----------------------------------------------------------------
   logic scl_m, scl_s, scl_d; // SCL stages and previous value
   logic sda_m, sda_s, sda_d; // SDA stages and previous value
   logic scl_rise, scl_fall, start_det, stop_det; // Bus events

   // Two stages, then one more for edge detection
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         scl_m <= 1'b1;
         scl_s <= 1'b1;
         scl_d <= 1'b1;
         sda_m <= 1'b1;
         sda_s <= 1'b1;
         sda_d <= 1'b1;
      end else begin
         scl_m <= SCL;
         scl_s <= scl_m;
         scl_d <= scl_s;
         sda_m <= SDA_IN;
         sda_s <= sda_m;
         sda_d <= sda_s;
      end
   end

   assign scl_rise = scl_s & ~scl_d;
   assign scl_fall = ~scl_s & scl_d;
   assign start_det = scl_s & scl_d & sda_d & ~sda_s;
   assign stop_det = scl_s & scl_d & ~sda_d & sda_s;

   // ----------------------------------------------------------------
   // Frame engine
   // ----------------------------------------------------------------
   link_state_t state; // Bus state
   logic [3:0] bit_cnt; // Bits of the current byte
   logic [7:0] shreg; // Receive and transmit shifter
   logic addr_phase; // Address byte in progress
   logic rw; // Direction bit of this frame
   logic matched; // Frame is addressed to us
   logic [1:0] nbytes; // Bytes after the address, saturating
   logic [7:0] cmd, dhi, dlo; // Register byte and two data bytes
   logic [1:0] tx_idx; // Next byte of a read answer
   logic mack; // Master acknowledged the last byte
   logic frame_end; // Pulse: write frame addressed to us ended
   logic [7:0] tx_byte; // Byte to send next
   logic [15:0] rd_word; // Selected register contents
   logic reg_ok; // Registers are reachable

   // Shift bytes in and out, acknowledge, count the frame
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         state <= ST_IDLE;
         bit_cnt <= 4'h0;
         shreg <= 8'h00;
         addr_phase <= 1'b0;
         rw <= 1'b0;
         matched <= 1'b0;
         nbytes <= 2'h0;
         cmd <= 8'h00;
         dhi <= 8'h00;
         dlo <= 8'h00;
         tx_idx <= 2'h0;
         mack <= 1'b0;
         frame_end <= 1'b0;
         SDA_OE <= 1'b0;
         SDA_OUT <= 1'b0;
      end else begin
         frame_end <= 1'b0;
         SDA_OUT <= 1'b0;
         if (start_det) begin // New frame
            state <= ST_RX;
            bit_cnt <= 4'h0;
            addr_phase <= 1'b1;
            matched <= 1'b0;
            nbytes <= 2'h0;
            SDA_OE <= 1'b0;
         end else if (stop_det) begin // Frame over
            state <= ST_IDLE;
            SDA_OE <= 1'b0;
            frame_end <= matched & ~rw;
         end else begin
            case (state)
               ST_RX: begin
                  if (scl_rise && bit_cnt != 4'h8) begin
                     shreg <= {shreg[6:0], sda_s};
                     bit_cnt <= bit_cnt + 4'h1;
                  end else if (scl_fall && bit_cnt == 4'h8) begin
                     if (addr_phase && shreg[7:1] != SLAVE_ADDR) begin
                        state <= ST_IDLE;
                     end else begin
                        SDA_OE <= 1'b1;
                        state <= ST_RX_ACK;
                        if (addr_phase) begin
                           rw <= shreg[0];
                           matched <= 1'b1;
                        end else begin
                           if (nbytes == 2'h0) cmd <= shreg;
                           if (nbytes == 2'h1) dhi <= shreg;
                           if (nbytes == 2'h2) dlo <= shreg;
                           if (nbytes != 2'h3) nbytes <= nbytes + 2'h1;
                        end
                     end
                  end
               end
               ST_RX_ACK: begin
                  if (scl_fall) begin
                     addr_phase <= 1'b0;
                     if (addr_phase && rw) begin // First answer byte
                        SDA_OE <= ~tx_byte[7];
                        shreg <= {tx_byte[6:0], 1'b0};
                        bit_cnt <= 4'h1;
                        tx_idx <= 2'h1;
                        state <= ST_TX;
                     end else begin
                        SDA_OE <= 1'b0;
                        bit_cnt <= 4'h0;
                        state <= ST_RX;
                     end
                  end
               end
               ST_TX: begin
                  if (scl_fall) begin
                     if (bit_cnt == 4'h8) begin
                        SDA_OE <= 1'b0;
                        state <= ST_TX_ACK;
                     end else begin
                        SDA_OE <= ~shreg[7];
                        shreg <= {shreg[6:0], 1'b0};
                        bit_cnt <= bit_cnt + 4'h1;
                     end
                  end
               end
               ST_TX_ACK: begin
                  if (scl_rise) mack <= ~sda_s;
                  if (scl_fall) begin
                     if (mack) begin // Next answer byte
                        SDA_OE <= ~tx_byte[7];
                        shreg <= {tx_byte[6:0], 1'b0};
                        bit_cnt <= 4'h1;
                        if (tx_idx != 2'h3) tx_idx <= tx_idx + 2'h1;
                        state <= ST_TX;
                     end else begin
                        state <= ST_IDLE;
                     end
                  end
               end
               default: state <= ST_IDLE;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // Register selection and answer bytes
   // ----------------------------------------------------------------
   logic [15:0] hum, tmp; // Resolution registers, 16 bits each
   logic [7:0] sel; // Register chosen for reading
   logic [CW-1:0] busy_cnt; // Processing or write time left
   logic [CW-1:0] win_cnt; // Time since power-up
   logic win_open, prog, entering; // Window, mode, entry pending

   // Read map of the configuration registers
   always_comb begin
      if (sel == nvm_access_pkg::HUM_RES_RD) rd_word = hum;
      else if (sel == nvm_access_pkg::TMP_RES_RD) rd_word = tmp;
      else if (sel == nvm_access_pkg::ID_UPPER_RD) rd_word = SENSOR_ID[31:16];
      else if (sel == nvm_access_pkg::ID_LOWER_RD) rd_word = SENSOR_ID[15:0];
      else rd_word = 16'h0000;
   end

   // Status first, then high and low byte of the register
   always_comb begin
      case ((state == ST_RX_ACK) ? 2'h0 : tx_idx)
         2'h0: tx_byte = reg_ok ? nvm_access_pkg::STATUS_OK : nvm_access_pkg::STATUS_BUSY;
         2'h1: tx_byte = rd_word[15:8];
         2'h2: tx_byte = rd_word[7:0];
         default: tx_byte = 8'h00;
      endcase
   end

   // ----------------------------------------------------------------
   // Programming mode and timing
   // ----------------------------------------------------------------
   logic enter_req, exit_req, sel_req, wr_hum, wr_tmp; // Accepted frames
   logic full_zero; // Three bytes with both data bytes zero

   assign reg_ok = prog & (busy_cnt == '0);
   assign full_zero = frame_end & (nbytes == 2'h3) & (dhi == 8'h00) & (dlo == 8'h00);
   assign enter_req = full_zero & (cmd == nvm_access_pkg::CMD_ENTER) & win_open & ~prog & ~entering;
   assign exit_req = full_zero & (cmd == nvm_access_pkg::CMD_EXIT) & reg_ok;
   assign sel_req = frame_end & (nbytes == 2'h1) & reg_ok;
   assign wr_hum = frame_end & (nbytes == 2'h3) & (cmd == nvm_access_pkg::HUM_RES_WR) & reg_ok;
   assign wr_tmp = frame_end & (nbytes == 2'h3) & (cmd == nvm_access_pkg::TMP_RES_WR) & reg_ok;

   // Power-up window, closes once and stays closed
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         win_cnt <= '0;
         win_open <= 1'b1;
      end else if (win_open) begin
         win_cnt <= win_cnt + 1'b1;
         if (win_cnt == CW'(WINDOW_CYC - 1)) win_open <= 1'b0;
      end
   end

   // Mode, processing delays and register selection
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         prog <= 1'b0;
         entering <= 1'b0;
         busy_cnt <= '0;
         sel <= 8'h00;
      end else begin
         if (enter_req || sel_req) busy_cnt <= CW'(PROC_CYC);
         else if (wr_hum || wr_tmp) busy_cnt <= CW'(NVWRITE_CYC);
         else if (busy_cnt != '0) busy_cnt <= busy_cnt - 1'b1;
         if (enter_req) entering <= 1'b1;
         else if (entering && busy_cnt == CW'(1)) entering <= 1'b0;
         if (entering && busy_cnt == CW'(1)) prog <= 1'b1;
         else if (exit_req) prog <= 1'b0;
         if (sel_req) sel <= cmd;
      end
   end

   // Stored settings; cleared only by power-on
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         hum <= nvm_access_pkg::RES_REG_RESET;
         tmp <= nvm_access_pkg::RES_REG_RESET;
         PROG_MODE <= 1'b0;
         HUM_RES_BITS <= 4'he;
         TEMP_RES_BITS <= 4'he;
      end else begin
         if (wr_hum) hum <= {dhi, dlo};
         if (wr_tmp) tmp <= {dhi, dlo};
         PROG_MODE <= prog;
         HUM_RES_BITS <= res_bits(hum[nvm_access_pkg::RES_MSB:nvm_access_pkg::RES_LSB]);
         TEMP_RES_BITS <= res_bits(tmp[nvm_access_pkg::RES_MSB:nvm_access_pkg::RES_LSB]);
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!RESETN);

   addr_ignore_a: assert property (
      state == ST_RX && scl_fall && bit_cnt == 4'h8 && addr_phase && !start_det && !stop_det
      && shreg[7:1] != SLAVE_ADDR |=> state == ST_IDLE && !SDA_OE)
      else $error("foreign address not ignored");
   entry_hold_a: assert property (
      enter_req |=> entering && !prog && busy_cnt == CW'(PROC_CYC))
      else $error("entry did not start processing");
   entry_time_a: assert property (
      $rose(prog) |-> $past(entering) && $past(busy_cnt) == CW'(1))
      else $error("programming mode entered early");
   window_a: assert property (!win_open |=> !win_open && !$rose(entering))
      else $error("entry accepted after window");
   status_a: assert property (
      state == ST_RX_ACK && scl_fall && addr_phase && rw && reg_ok && !start_det && !stop_det
      |=> !SDA_OE && shreg == {nvm_access_pkg::STATUS_OK[6:0], 1'b0} && tx_idx == 2'h1)
      else $error("status byte wrong");
   hum_write_a: assert property (
      wr_hum && !wr_tmp |=> hum == {$past(dhi), $past(dlo)} && $stable(tmp)
      && busy_cnt == CW'(NVWRITE_CYC))
      else $error("humidity write wrong");
   res_map_a: assert property (
      1'b1 |=> HUM_RES_BITS == res_bits($past(hum[11:10])))
      else $error("humidity resolution decode wrong");
   id_map_a: assert property (
      state == ST_TX_ACK && scl_fall && mack && tx_idx == 2'h1 && !start_det && !stop_det
      && sel == nvm_access_pkg::ID_LOWER_RD
      |=> SDA_OE == ~SENSOR_ID[15] && shreg == {SENSOR_ID[14:8], 1'b0} && tx_idx == 2'h2)
      else $error("lower ID word wrong");
   nv_keep_a: assert property (!wr_tmp |=> $stable(tmp))
      else $error("temperature setting changed without write");

   enter_c: cover property ($rose(prog));
   read_c: cover property (state == ST_TX_ACK && scl_fall && mack);
   write_c: cover property (wr_tmp);
endmodule : nvm_access
`default_nettype wire

// file: tb/i2c_host_model.sv
/*
 Behavioural bus master facing the configuration access block.
 Assumes an open-drain SDA wire with a pull-up, resolved by the bench.
*/
`timescale 1ns/10ps
`default_nettype none
module i2c_host_model #(
   parameter int HALF_NS = 63 // SCL high phase; low phase 2*(HALF_NS/2), 125 ns bit
) (
   input wire logic sda, // Resolved bus data level
   output logic scl, // Bus clock, stands high between frames
   output logic sda_oe, // High while pulling SDA low
   output logic [7:0] rx_byte, // Last byte read from the device
   output logic rx_stb // Pulses when rx_byte is fresh
);
   localparam int Q = HALF_NS / 2; // Data changes mid low phase
   // Idle bus: clock high, data released
   initial begin
      scl = 1'b1;
      sda_oe = 1'b0;
      rx_byte = 8'h00;
      rx_stb = 1'b0;
   end
   // SDA falls while SCL is high, then clock goes low
   task automatic start_cond();
      sda_oe = 1'b1;
      #(HALF_NS);
      scl = 1'b0;
      #(Q);
   endtask : start_cond
   // SDA rises while SCL is high, then bus free time
   task automatic stop_cond();
      sda_oe = 1'b1;
      #(Q);
      scl = 1'b1;
      #(HALF_NS);
      sda_oe = 1'b0;
      #(HALF_NS);
   endtask : stop_cond
   // One bit: set data in low phase, sample it late in the high phase
   task automatic put_bit(input logic b, output logic got);
      sda_oe = ~b;
      #(Q);
      scl = 1'b1;
      #(HALF_NS);
      got = sda;
      scl = 1'b0;
      #(Q);
   endtask : put_bit
   // Byte out MSB first, then release for the device's answer bit
   task automatic send_byte(input logic [7:0] b, output logic ack);
      logic dummy;
      for (int i = 7; i >= 0; i--) put_bit(b[i], dummy);
      put_bit(1'b1, ack);
   endtask : send_byte
   // Byte in MSB first; acknowledge unless it is the last one
   task automatic recv_byte(input logic last);
      logic [7:0] d;
      logic dummy;
      for (int i = 7; i >= 0; i--) put_bit(1'b1, d[i]);
      put_bit(last, dummy);
      rx_byte = d;
      rx_stb = 1'b1;
      #1 rx_stb = 1'b0;
   endtask : recv_byte
endmodule : i2c_host_model
`default_nettype wire

// file: tb/nvm_access_tb.sv
/*
 Self-checking bench for the configuration access block.
 Assumes the host model file is compiled first, with the design.
*/
`timescale 1ns/10ps
`default_nettype none
module nvm_access_tb;
   localparam int PROC = 200; // Shortened processing count
   localparam int NVW = 500; // Shortened write count
   localparam logic [6:0] ADDR = 7'h44; // Own bus address
   localparam logic [31:0] ID = 32'hc3e1_7b29; // Arbitrary value
   logic clk, rstn, scl, host_oe, sda, sda_out, sda_oe, prog, rx_stb;
   logic [3:0] hum_bits, tmp_bits; // Decoded resolutions
   logic [7:0] rx_byte; // Byte read by the host
   logic [7:0] exp_q[$]; // Expected read bytes, oldest first
   logic [15:0] cur, val; // Register image for read-modify-write
   logic [1:0] code; // Resolution code under test
   int error_cnt = 0;
   int n_checks = 0;
   int seed = 48250;
   int rot;
   // Open-drain wire with pull-up
   assign sda = (sda_oe ? sda_out : 1'b1) & ~host_oe;
   nvm_access #(.SLAVE_ADDR(ADDR), .SENSOR_ID(ID), .WINDOW_CYC(5000),
      .PROC_CYC(PROC), .NVWRITE_CYC(NVW)) DUT (.CORE_CLK(clk), .RESETN(rstn),
      .SCL(scl), .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE(sda_oe), .PROG_MODE(prog),
      .HUM_RES_BITS(hum_bits), .TEMP_RES_BITS(tmp_bits));
   i2c_host_model #(.HALF_NS(63)) host (.sda(sda), .scl(scl), .sda_oe(host_oe),
      .rx_byte(rx_byte), .rx_stb(rx_stb));
   // ------------------------------------------------------------
   // Checking and closing
   // ------------------------------------------------------------
   task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : cmp_byte
   task automatic cmp_lvl(input logic [3:0] got, input logic [3:0] exp, input string what);
      cmp_byte({4'h0, got}, {4'h0, exp}, what);
   endtask : cmp_lvl
   task automatic final_report();
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : final_report
   // ------------------------------------------------------------
   // Bus sequences
   // ------------------------------------------------------------
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : wait_cyc
   // Address with write bit, one byte, then n data bytes high first
   task automatic frame(input logic [6:0] a, input logic [7:0] b0, input int n,
      input logic [15:0] d, input logic exp_ack);
      logic ack;
      host.start_cond();
      host.send_byte({a, 1'b0}, ack);
      cmp_lvl({3'h0, ack}, {3'h0, ~exp_ack}, "address answer");
      host.send_byte(b0, ack);
      for (int i = 0; i < n; i++) host.send_byte(d[15 - 8 * i -: 8], ack);
      host.stop_cond();
   endtask : frame
   // Read frame: note status and both bytes, then clock them in
   task automatic rd_data(input logic [7:0] st, input logic [15:0] v);
      logic ack;
      exp_q.push_back(st);
      exp_q.push_back(v[15:8]);
      exp_q.push_back(v[7:0]);
      host.start_cond();
      host.send_byte({ADDR, 1'b1}, ack);
      cmp_lvl({3'h0, ack}, 4'h0, "read address answer");
      for (int i = 0; i < 3; i++) host.recv_byte(i == 2);
      host.stop_cond();
   endtask : rd_data
   // Select a register, let it load, then read it
   task automatic rd_reg(input logic [7:0] r, input logic [15:0] v);
      frame(ADDR, r, 0, 16'h0000, 1'b1);
      wait_cyc(PROC + 20);
      rd_data(8'h81, v);
   endtask : rd_reg
   // Free-running clock, 10 ns period
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Watchdog at about 2.4 times the expected run length
   initial begin
      #400000;
      error_cnt++;
      $display("wrong value at %0t: run timed out", $time);
      final_report();
   end
   // Monitor: each byte read is matched with the oldest note
   initial begin
      forever begin
         @(posedge rx_stb);
         cmp_byte(rx_byte, exp_q.pop_front(), "read byte");
      end
   end
   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      rstn = 1'b0;
      repeat (20) @(posedge clk);
      #1 rstn = 1'b1;
      wait_cyc(5);
      cmp_lvl({3'h0, prog}, 4'h0, "mode after reset");
      cmp_lvl(hum_bits, 4'he, "humidity default");
      cmp_lvl(tmp_bits, 4'he, "temperature default");
      $display("test reset done");
      // Read before programming mode: not-ready status, nothing selected
      rd_data(8'h00, 16'h0000);
      $display("test early read done");
      // Entry sent to another address is ignored
      frame(ADDR ^ 7'h01, 8'ha0, 2, 16'h0000, 1'b0);
      wait_cyc(PROC + 40);
      cmp_lvl({3'h0, prog}, 4'h0, "mode after foreign entry");
      $display("test foreign address done");
      // Entry within the window, mode only after processing
      frame(ADDR, 8'ha0, 2, 16'h0000, 1'b1);
      wait_cyc(PROC - 20);
      cmp_lvl({3'h0, prog}, 4'h0, "mode while processing");
      wait_cyc(40);
      cmp_lvl({3'h0, prog}, 4'h1, "mode after processing");
      $display("test entry done");
      rd_reg(8'h06, 16'h0c00);
      rd_reg(8'h11, 16'h0c00);
      rd_reg(8'h1e, ID[31:16]);
      rd_reg(8'h1f, ID[15:0]);
      $display("test register reads done");
      // Every code once, starting from a random one
      rot = $random(seed);
      cur = 16'h0c00;
      for (int i = 0; i < 4; i++) begin
         code = 2'(rot + i);
         val = cur;
         val[11:10] = code;
         frame(ADDR, 8'h46, 2, val, 1'b1);
         wait_cyc(NVW + 20);
         cmp_lvl(hum_bits, 4'h8 + {1'b0, code, 1'b0}, "humidity bits");
         cmp_lvl(tmp_bits, 4'he, "temperature kept");
         rd_reg(8'h06, val);
         cur = val;
      end
      frame(ADDR, 8'h51, 2, 16'h0400, 1'b1);
      wait_cyc(NVW + 20);
      cmp_lvl(tmp_bits, 4'ha, "temperature bits");
      cmp_lvl(hum_bits, 4'h8 + {1'b0, code, 1'b0}, "humidity kept");
      rd_reg(8'h11, 16'h0400);
      $display("test resolution writes done");
      // Exit, then a late entry must be refused
      frame(ADDR, 8'h80, 2, 16'h0000, 1'b1);
      wait_cyc(20);
      cmp_lvl({3'h0, prog}, 4'h0, "mode after exit");
      frame(ADDR, 8'ha0, 2, 16'h0000, 1'b1);
      wait_cyc(PROC + 40);
      cmp_lvl({3'h0, prog}, 4'h0, "mode after late entry");
      $display("test exit and late entry done");
      cmp_byte(8'(exp_q.size()), 8'h00, "reads left over");
      final_report();
   end
endmodule : nvm_access_tb
`default_nettype wire
